// ### design/ifs_timing_pkg.sv
// holds the constants of the interframe timing and link quality block
// assumes a single 250 MHz clock shared by every design file
package ifs_timing_pkg;

    // --------------------------------------------------------------
    // clock and timing constants
    // --------------------------------------------------------------
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned MIN_GAP_TIME_US = 2;         // burst mode gap
    localparam int unsigned SHORT_GAP_TIME_US = 10;      // normal mode gap
    localparam int unsigned SLOT_DURATION_US = 15;
    localparam int unsigned CHANNEL_ASSESS_TIME_US = 10;
    localparam int unsigned MIN_GAP_CYCLES = MIN_GAP_TIME_US * CLOCK_MHZ;
    localparam int unsigned SHORT_GAP_CYCLES = SHORT_GAP_TIME_US * CLOCK_MHZ;
    localparam int unsigned SLOT_CYCLES = SLOT_DURATION_US * CLOCK_MHZ;
    localparam int unsigned CHANNEL_ASSESS_CYCLES = CHANNEL_ASSESS_TIME_US * CLOCK_MHZ;
    // turnaround budget: strictly below the short gap
    localparam int unsigned TURNAROUND_CYCLES = SHORT_GAP_CYCLES - 1;
    localparam int unsigned COUNT_W = 12;

    // --------------------------------------------------------------
    // link quality code layout
    // --------------------------------------------------------------
    localparam int unsigned SNR_W = 8;                   // signed whole dB
    localparam int unsigned CODE_W = 8;
    localparam logic signed [SNR_W-1:0] SNR_MIN_DB = -8'sd10;
    localparam logic signed [SNR_W-1:0] SNR_MAX_DB = 8'sd40;
    localparam logic [CODE_W-1:0] CODE_UNSUPPORTED = 8'h00;
    localparam logic [CODE_W-1:0] CODE_LOWEST = 8'h01;
    localparam logic [CODE_W-1:0] CODE_HIGHEST = 8'h33;

endpackage : ifs_timing_pkg

// ### design/link_quality_quantizer.sv
// maps a whole-dB mean SNR estimate to the link quality code
// assumes the estimate is already rounded to 1 dB steps upstream
`timescale 1ns/100ps
module link_quality_quantizer
    import ifs_timing_pkg::*;
(
    input wire logic signed [SNR_W-1:0] snr_db,
    input wire logic supported,
    output logic [CODE_W-1:0] code
);

    // --------------------------------------------------------------
    // clamp and offset
    // --------------------------------------------------------------
    // the offset keeps zero free for the unsupported marker
    always_comb begin
        if (!supported) begin
            code = CODE_UNSUPPORTED;                  // see RULE10
        end else if (snr_db <= SNR_MIN_DB) begin
            code = CODE_LOWEST;                       // see RULE9
        end else if (snr_db >= SNR_MAX_DB) begin
            code = CODE_HIGHEST;                      // see RULE9
        end else begin
            code = CODE_W'(snr_db - SNR_MIN_DB + 8'sd1); // see RULE8 see RULE12
        end
    end

endmodule : link_quality_quantizer

// ### design/interframe_timing_and_link_quality.sv
// top of the interframe gap timer and the link quality coder
// assumes the scheduler and the baseband chain sit on the same clock
//
// Behaviour
// RULE1: normal mode gap between transmissions is exactly 10 us.
// RULE2: burst mode gap between transmissions is exactly 2 us.
// RULE3: gap is chosen only from the minimum and short values by mode.
// RULE4: slot 15 us and channel assessment 10 us are held as constants.
// RULE5: receive-to-transmit turnaround ends before the short gap elapses.
// RULE6: transmit-to-receive turnaround ends before the short gap elapses.
// RULE7: link quality comes from the mean post-FFT packet SNR estimate.
// RULE8: SNR quantised in 1 dB steps from -10 dB to +40 dB.
// RULE9: estimates outside the range clamp to the lowest or highest code.
// RULE10: without estimation support the field is all zeros.
// RULE11: the field carries either unsupported or the quantised estimate.
// RULE12: code 1 is -10 dB, 51 is +40 dB, above 51 never produced.
// RULE13: count cycles from end of transmission, release at the gap count.
`timescale 1ns/100ps
module interframe_timing_and_link_quality
    import ifs_timing_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic burst_mode,
    input wire logic tx_end,
    input wire logic rx_end,
    input wire logic tx_request,
    input wire logic snr_valid,
    input wire logic signed [SNR_W-1:0] snr_db,
    input wire logic lq_supported,
    output logic tx_grant,
    output logic gap_busy,
    output logic rx_to_tx_ready,
    output logic tx_to_rx_ready,
    output logic slot_tick,
    output logic channel_assess_done,
    output logic lq_valid,
    output logic [CODE_W-1:0] link_quality_code
);

    typedef enum logic [1:0] {IDLE, GAP, READY} gap_state_e;

    // --------------------------------------------------------------
    // interframe gap timer
    // --------------------------------------------------------------
    gap_state_e state;
    gap_state_e next_state;
    logic [COUNT_W-1:0] gap_count;
    logic [COUNT_W-1:0] next_gap_count;
    logic [COUNT_W-1:0] gap_target;
    logic next_tx_grant;
    logic next_gap_busy;

    // mode is sampled at every count so a late mode change moves the target of the gap already running
    always_comb begin
        gap_target = burst_mode ? COUNT_W'(MIN_GAP_CYCLES)
                                : COUNT_W'(SHORT_GAP_CYCLES); // see RULE3
        next_state = state;
        next_gap_count = gap_count;
        next_tx_grant = 1'b0;
        next_gap_busy = gap_busy;
        case (state)
            IDLE: begin
                next_gap_busy = 1'b0;
                if (tx_end) begin
                    next_state = GAP;
                    next_gap_count = COUNT_W'(1);
                    next_gap_busy = 1'b1;
                end else if (tx_request) begin
                    next_tx_grant = 1'b1;
                end
            end
            GAP: begin
                // counting starts at the end of transmission; see RULE13
                if (gap_count >= gap_target - COUNT_W'(1)) begin
                    next_state = READY;               // see RULE1 see RULE2
                    next_gap_busy = 1'b0;
                end else begin
                    next_gap_count = gap_count + COUNT_W'(1);
                end
            end
            READY: begin
                // a request held through the gap is released on the exact boundary
                if (tx_end) begin
                    next_state = GAP;
                    next_gap_count = COUNT_W'(1);
                    next_gap_busy = 1'b1;
                end else if (tx_request) begin
                    next_tx_grant = 1'b1;             // see RULE13
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
                next_gap_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= IDLE;
            gap_count <= '0;
            tx_grant <= 1'b0;
            gap_busy <= 1'b0;
        end else begin
            state <= next_state;
            gap_count <= next_gap_count;
            tx_grant <= next_tx_grant;
            gap_busy <= next_gap_busy;
        end
    end

    // --------------------------------------------------------------
    // turnaround timers
    // --------------------------------------------------------------
    logic [COUNT_W-1:0] rtg_count;
    logic [COUNT_W-1:0] next_rtg_count;
    logic [COUNT_W-1:0] ttg_count;
    logic [COUNT_W-1:0] next_ttg_count;
    logic next_rx_to_tx_ready;
    logic next_tx_to_rx_ready;

    // ready is reached one cycle under the short gap, keeping margin for the gap timer
    always_comb begin
        next_rtg_count = rtg_count;
        next_ttg_count = ttg_count;
        next_rx_to_tx_ready = rx_to_tx_ready;
        next_tx_to_rx_ready = tx_to_rx_ready;
        if (rx_end) begin
            next_rtg_count = COUNT_W'(1);
            next_rx_to_tx_ready = 1'b0;
        end else if (!rx_to_tx_ready) begin
            if (rtg_count >= COUNT_W'(TURNAROUND_CYCLES)) begin
                next_rx_to_tx_ready = 1'b1;           // see RULE5
            end else begin
                next_rtg_count = rtg_count + COUNT_W'(1);
            end
        end
        if (tx_end) begin
            next_ttg_count = COUNT_W'(1);
            next_tx_to_rx_ready = 1'b0;
        end else if (!tx_to_rx_ready) begin
            if (ttg_count >= COUNT_W'(TURNAROUND_CYCLES)) begin
                next_tx_to_rx_ready = 1'b1;           // see RULE6
            end else begin
                next_ttg_count = ttg_count + COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rtg_count <= '0;
            ttg_count <= '0;
            rx_to_tx_ready <= 1'b1;
            tx_to_rx_ready <= 1'b1;
        end else begin
            rtg_count <= next_rtg_count;
            ttg_count <= next_ttg_count;
            rx_to_tx_ready <= next_rx_to_tx_ready;
            tx_to_rx_ready <= next_tx_to_rx_ready;
        end
    end

    // --------------------------------------------------------------
    // slot and channel assessment timers
    // --------------------------------------------------------------
    logic [COUNT_W-1:0] slot_count;
    logic [COUNT_W-1:0] next_slot_count;
    logic [COUNT_W-1:0] cca_count;
    logic [COUNT_W-1:0] next_cca_count;
    logic next_slot_tick;
    logic next_channel_assess_done;

    // free-running slot divider; assessment window restarts at each end of receive or transmit
    always_comb begin
        next_slot_tick = 1'b0;
        next_slot_count = slot_count + COUNT_W'(1);
        if (slot_count >= COUNT_W'(SLOT_CYCLES - 1)) begin
            next_slot_count = '0;
            next_slot_tick = 1'b1;                    // see RULE4
        end
        next_cca_count = cca_count;
        next_channel_assess_done = channel_assess_done;
        if (rx_end || tx_end) begin
            next_cca_count = '0;
            next_channel_assess_done = 1'b0;
        end else if (!channel_assess_done) begin
            if (cca_count >= COUNT_W'(CHANNEL_ASSESS_CYCLES - 1)) begin
                next_channel_assess_done = 1'b1;      // see RULE4
            end else begin
                next_cca_count = cca_count + COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slot_count <= '0;
            cca_count <= '0;
            slot_tick <= 1'b0;
            channel_assess_done <= 1'b0;
        end else begin
            slot_count <= next_slot_count;
            cca_count <= next_cca_count;
            slot_tick <= next_slot_tick;
            channel_assess_done <= next_channel_assess_done;
        end
    end

    // --------------------------------------------------------------
    // link quality field
    // --------------------------------------------------------------
    logic [CODE_W-1:0] quant_code;
    logic [CODE_W-1:0] next_link_quality_code;
    logic next_lq_valid;

    link_quality_quantizer quantizer (
        .snr_db(snr_db),
        .supported(lq_supported),
        .code(quant_code)
    );

    // one code per packet estimate; the field holds until the next estimate
    always_comb begin
        next_lq_valid = snr_valid;
        next_link_quality_code = link_quality_code;
        if (snr_valid) begin
            next_link_quality_code = quant_code;      // see RULE7 see RULE11
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lq_valid <= 1'b0;
            link_quality_code <= CODE_UNSUPPORTED;
        end else begin
            lq_valid <= next_lq_valid;
            link_quality_code <= next_link_quality_code;
        end
    end

endmodule : interframe_timing_and_link_quality

// ### test/ifs_timing_properties.sv
// concurrent checks on the gap timer, turnarounds and link quality coder
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/100ps
module ifs_timing_properties
    import ifs_timing_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic burst_mode,
    input wire logic tx_end,
    input wire logic rx_end,
    input wire logic tx_request,
    input wire logic snr_valid,
    input wire logic signed [SNR_W-1:0] snr_db,
    input wire logic lq_supported,
    input wire logic tx_grant,
    input wire logic gap_busy,
    input wire logic rx_to_tx_ready,
    input wire logic tx_to_rx_ready,
    input wire logic slot_tick,
    input wire logic channel_assess_done,
    input wire logic lq_valid,
    input wire logic [CODE_W-1:0] link_quality_code
);
    localparam logic [COUNT_W-1:0] TURN_LIMIT = COUNT_W'(SHORT_GAP_CYCLES - 1);
    localparam logic [COUNT_W-1:0] CCA_LIMIT = COUNT_W'(CHANNEL_ASSESS_CYCLES);
    localparam logic [COUNT_W-1:0] SLOT_LIMIT = COUNT_W'(SLOT_CYCLES);
    logic [COUNT_W-1:0] busy_cnt;
    logic [COUNT_W-1:0] rx_since;
    logic [COUNT_W-1:0] tx_since;
    logic [COUNT_W-1:0] cca_since;
    logic [COUNT_W-1:0] slot_since;
    // cycles spent timing a gap; cleared whenever the timer is idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) busy_cnt <= '0;
        else busy_cnt <= gap_busy ? busy_cnt + 12'h001 : 12'h000;
    end
    // cycles since each restart event; saturating so a quiet link stays settled
    // the windows are too long for a delay range, so they are counted here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_since <= 12'hfff;
            tx_since <= 12'hfff;
            cca_since <= 12'h000;
            slot_since <= 12'h000;
        end else begin
            rx_since <= rx_end ? 12'h000 : rx_since + 12'(rx_since != 12'hfff);
            tx_since <= tx_end ? 12'h000 : tx_since + 12'(tx_since != 12'hfff);
            cca_since <= (rx_end || tx_end) ? 12'h000 : cca_since + 12'(cca_since != 12'hfff);
            slot_since <= slot_tick ? 12'h001 : slot_since + 12'(slot_since != 12'hfff);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_gap_start: assert property (tx_end && !gap_busy |=> gap_busy)
        else $error("gap timer did not start");
    chk_gap_burst: assert property ($fell(gap_busy) && burst_mode |-> busy_cnt == 499)
        else $error("burst gap length wrong");
    chk_gap_normal: assert property ($fell(gap_busy) && !burst_mode |-> busy_cnt == 2499)
        else $error("normal gap length wrong");
    chk_grant_blocked: assert property (gap_busy |-> !tx_grant)
        else $error("grant during gap");
    chk_grant_release: assert property ($fell(gap_busy) && tx_request |=> tx_grant)
        else $error("no grant after gap");
    chk_rx_turn: assert property (rx_to_tx_ready == (rx_since >= TURN_LIMIT))
        else $error("receive to transmit turnaround wrong");
    chk_tx_turn: assert property (tx_to_rx_ready == (tx_since >= TURN_LIMIT))
        else $error("transmit to receive turnaround wrong");
    chk_cca_window: assert property (channel_assess_done == (cca_since >= CCA_LIMIT))
        else $error("channel assessment window wrong");
    chk_slot_period: assert property (slot_tick == (slot_since == SLOT_LIMIT))
        else $error("slot tick period wrong");
    chk_lq_follow: assert property (snr_valid |=> lq_valid)
        else $error("no code after estimate");
    chk_code_unsup: assert property (snr_valid && !lq_supported |=> link_quality_code == 8'h00)
        else $error("unsupported code not zero");
    chk_clamp_low: assert property (snr_valid && lq_supported && snr_db <= SNR_MIN_DB |=>
        link_quality_code == 8'h01) else $error("low clamp wrong");
    chk_clamp_high: assert property (snr_valid && lq_supported && snr_db >= SNR_MAX_DB |=>
        link_quality_code == 8'h33) else $error("high clamp wrong");
    chk_code_step: assert property (snr_valid && lq_supported && snr_db > SNR_MIN_DB &&
        snr_db < SNR_MAX_DB |=> link_quality_code == 8'($past(snr_db) + 8'sd11))
        else $error("code step wrong");
endmodule : ifs_timing_properties
bind interframe_timing_and_link_quality ifs_timing_properties chk (
    .clock(clock), .rst(rst), .burst_mode(burst_mode), .tx_end(tx_end), .rx_end(rx_end),
    .tx_request(tx_request), .snr_valid(snr_valid), .snr_db(snr_db),
    .lq_supported(lq_supported), .tx_grant(tx_grant), .gap_busy(gap_busy),
    .rx_to_tx_ready(rx_to_tx_ready), .tx_to_rx_ready(tx_to_rx_ready),
    .slot_tick(slot_tick), .channel_assess_done(channel_assess_done),
    .lq_valid(lq_valid), .link_quality_code(link_quality_code)
);

// ### test/scheduler_model.sv
// scheduler stand-in that raises a transmit request and holds it to the grant
// assumes the same clock and reset as the block
`timescale 1ns/100ps
module scheduler_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic want,
    input wire logic [3:0] lag,
    input wire logic tx_grant,
    output logic tx_request
);
    logic [3:0] wait_cnt;
    logic done;
    // one grant per want; lag lets the scheduler answer slowly
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_request <= 1'b0;
            done <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (tx_grant) begin
            tx_request <= 1'b0;
            done <= 1'b1;
        end else if (!want) begin
            done <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (!done && wait_cnt < lag) wait_cnt <= wait_cnt + 4'h1;
        else if (!done) tx_request <= 1'b1;
    end
endmodule : scheduler_model

// ### test/test_interframe_timing_and_link_quality.sv
// self-checking bench for the gap timer and link quality coder
// assumes the scheduler model stands on the transmit request side
`timescale 1ns/100ps
module test_interframe_timing_and_link_quality;
    import ifs_timing_pkg::*;
    logic clock = 0, rst = 1, burst_mode = 0, tx_end = 0, rx_end = 0, want = 0;
    logic snr_valid = 0, lq_supported = 1, tx_request, tx_grant, gap_busy, lq_valid;
    logic rx_to_tx_ready, tx_to_rx_ready, slot_tick, channel_assess_done;
    logic [3:0] lag = 4'h0;
    logic signed [SNR_W-1:0] snr_db = '0;
    logic [CODE_W-1:0] link_quality_code;
    logic [15:0] code_q[$], gap_q[$], since_end = 16'h0000, slot_gap = 16'h0000;
    int fails = 0, tests_run = 0, n;
    always #2 clock = ~clock;
    interframe_timing_and_link_quality DUT (.clock(clock), .rst(rst), .burst_mode(burst_mode),
        .tx_end(tx_end), .rx_end(rx_end), .tx_request(tx_request), .snr_valid(snr_valid),
        .snr_db(snr_db), .lq_supported(lq_supported), .tx_grant(tx_grant),
        .gap_busy(gap_busy), .rx_to_tx_ready(rx_to_tx_ready), .tx_to_rx_ready(tx_to_rx_ready),
        .slot_tick(slot_tick), .channel_assess_done(channel_assess_done), .lq_valid(lq_valid),
        .link_quality_code(link_quality_code));
    scheduler_model partner (.clock(clock), .rst(rst), .want(want), .lag(lag),
        .tx_grant(tx_grant), .tx_request(tx_request));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // bounded wait on a level; running out counts as a mismatch and ends the run
    task automatic wait_for(ref logic sig, input int limit);
        for (n = 0; n < limit && sig !== 1'b1; n++) @(posedge clock);
        if (sig !== 1'b1) begin
            fails++;
            print_verdict();
        end
    endtask : wait_for
    // one estimate per call, so calls run back to back; caller drops the strobe
    task automatic snr(input logic signed [SNR_W-1:0] v, input logic sup);
        logic signed [8:0] s;
        s = v;
        snr_db <= v;
        lq_supported <= sup;
        snr_valid <= 1'b1;
        code_q.push_back(!sup ? 16'(CODE_UNSUPPORTED) : s <= SNR_MIN_DB ? 16'(CODE_LOWEST) :
            s >= SNR_MAX_DB ? 16'(CODE_HIGHEST) : 16'(s + 9'sd11));
        @(posedge clock);
    endtask : snr
    // the request is held through the gap, so grant lands exactly the gap length after tx_end
    task automatic gap(input logic burst, input int cycles);
        burst_mode <= burst;
        lag <= 4'($urandom_range(0, 9));
        tx_end <= 1'b1;
        want <= 1'b1;
        gap_q.push_back(16'(cycles));
        @(posedge clock);
        tx_end <= 1'b0;
        wait_for(tx_grant, cycles + 20);
        want <= 1'b0;
        wait_for(tx_to_rx_ready, 3000);
        $display("test gap burst=%0d done", burst);
    endtask : gap
    // results are taken off the queues in the order the outputs report them
    always @(posedge clock) begin
        since_end <= tx_end ? 16'h0000 : since_end + 16'h0001;
        // slot ticks run free from reset release, one every slot period
        slot_gap <= rst ? 16'h0000 : slot_tick ? 16'h0001 : slot_gap + 16'h0001;
        if (slot_tick === 1'b1) check(slot_gap, 16'(SLOT_CYCLES));
        if (lq_valid === 1'b1 && code_q.size() > 0) check(16'(link_quality_code), code_q.pop_front());
        if (tx_grant === 1'b1 && gap_q.size() > 0) check(since_end, gap_q.pop_front());
    end
    initial begin
        n = $urandom(32'h884a77cc);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check(16'(link_quality_code), 16'h0000);
        $display("test reset done");
        for (int v = -20; v <= 50; v++) snr(8'(v), 1'b1);
        for (int i = 0; i < 40; i++) snr(8'($urandom), 1'($urandom));
        snr_valid <= 1'b0;
        repeat (3) @(posedge clock);
        check(16'(code_q.size()), 16'h0000);
        $display("test link quality done");
        gap(1'b1, MIN_GAP_CYCLES);
        gap(1'b0, SHORT_GAP_CYCLES);
        rx_end <= 1'b1;
        @(posedge clock);
        rx_end <= 1'b0;
        repeat (2) @(posedge clock);
        check(16'(rx_to_tx_ready), 16'h0000);
        wait_for(rx_to_tx_ready, 3000);
        check(16'(channel_assess_done), 16'h0000);
        @(posedge clock);
        check(16'(channel_assess_done), 16'h0001);
        $display("test turnaround done");
        print_verdict();
    end
endmodule : test_interframe_timing_and_link_quality
